// >>> hw/acc_conv_ctrl.sv
// converter control, result registers and register bus slave
`timescale 1ns/1ns

// How it works
// [R1] single mode: each software write of one to start while idle, with enable also written one, begins one conversion
// [R2] free running: first start write launches, later conversions restart; a control write in the completing cycle blocks the restart
// [R3] first conversion after enabling takes 25 converter clocks, others 13
// [R4] start bit reads one while busy, clears at completion; writing zero inert
// [R5] with auto trigger on, rising edge of selected source starts a conversion
// [R6] completion flag sets when a conversion ends and results are updated
// [R7] interrupt requested only when flag, its enable and global enable all set
// [R8] flag cleared by vector taken or by writing one to it
// [R9] prescaler codes divide system clock by 2,2,4,8,16,32,64,128
// [R10] reading low byte freezes both result bytes until high byte is read
// [R11] left adjust picks result byte layout, reformatting at once
// [R12] comparator negative input from converter mux when enabled and converter off
// [R13] trigger source field ignored while auto trigger is off
// [R14] trigger is rising edge of selected flag, switching sources included
// [R15] free running code never makes a trigger event
// [R16] trigger codes select free run, comparator, int0, timer events
// [R17] disable bit kills pin digital input; port input bit reads zero
// [R18] clearing enable mid conversion aborts it and turns converter off
// [R19] channel and reference changes apply only after current conversion ends
// [R20] result captured with the flag unless the read lock holds it
module acc_conv_ctrl
  import acc_pkg::*;
#(
  parameter int ADDR_W = 10
) (
  input wire logic CLK,
  input wire logic SYS_RST,
  input wire logic [ADDR_W-1:0] S_AXI_AWADDR,
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  output logic [1:0] S_AXI_BRESP,
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  input wire logic [ADDR_W-1:0] S_AXI_ARADDR,
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  output logic [31:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP,
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  input wire logic GLOBAL_INT_EN,
  input wire logic VECTOR_TAKEN,
  input wire logic [7:0] TRIG_FLAGS,
  input wire logic [9:0] CORE_RESULT,
  input wire logic [7:0] PIN_LEVELS,
  output logic IRQ,
  output logic CORE_ACTIVE,
  output logic CORE_SAMPLE,
  output logic [3:0] CORE_CHANNEL,
  output logic [1:0] CORE_REFERENCE,
  output logic COMP_NEG_FROM_MUX,
  output logic [7:0] DIG_IN_DISABLE,
  output logic [7:0] PORT_IN_VALUE
);
  import acc_pkg::*;

  initial begin
    if (ADDR_W < 10) $error("acc_conv_ctrl: ADDR_W must be at least 10");
  end

  // ---------------------------------------------------------------
  // register state
  // ---------------------------------------------------------------
  logic enable_q, auto_q, irq_en_q, flag_q, left_q, comparator_mux_enable_q;
  logic [2:0] ps_q, ts_q;
  logic [1:0] ref_q;
  logic [3:0] chan_q;
  logic [7:0] didr_q;
  logic [9:0] result_q;
  logic lock_q, busy_q, first_q, sel_prev_q;
  logic [4:0] left_cnt_q;
  logic tick;
  logic [9:0] core_res_s;
  logic [7:0] pins_s;

  // ---------------------------------------------------------------
  // bus decode
  // ---------------------------------------------------------------
  logic wr_fire, rd_fire, wr_lane;
  logic [7:0] wr_idx, rd_idx, wr_byte;
  logic wr_ctrl, flag_clr, start_req, conv_done;
  logic sel_level, trig_edge, free_restart, sw_start;
  logic [7:0] res_low, res_high, rd_byte;
  logic rd_hit;

  assign wr_fire = S_AXI_AWREADY;
  assign rd_fire = S_AXI_ARREADY;
  assign wr_idx = S_AXI_AWADDR[9:2];
  assign rd_idx = S_AXI_ARADDR[9:2];
  assign wr_lane = S_AXI_WSTRB[0];
  assign wr_byte = S_AXI_WDATA[7:0];
  assign wr_ctrl = wr_fire && wr_lane && wr_idx == IDX_CTRL_STATUS;

  // pins and analog core outputs come from outside the clock domain
  acc_sync2 #(.WIDTH(10)) u_res_sync (
    .CLK(CLK),
    .SYS_RST(SYS_RST),
    .D(CORE_RESULT),
    .Q(core_res_s)
  );
  acc_sync2 #(.WIDTH(8)) u_pin_sync (
    .CLK(CLK),
    .SYS_RST(SYS_RST),
    .D(PIN_LEVELS),
    .Q(pins_s)
  );
  acc_prescale u_presc (
    .CLK(CLK),
    .SYS_RST(SYS_RST),
    .RUN(enable_q),
    .SEL(ps_q),
    .TICK(tick) // [R9]
  );

  // ---------------------------------------------------------------
  // conversion starts
  // ---------------------------------------------------------------
  // trigger level is zero for the free running code
  assign sel_level = (ts_q == TS_FREE_RUN) ? 1'b0 : TRIG_FLAGS[ts_q]; // [R16]
  // previous level follows the selection, so a switch from a clear source to a set source is an edge
  assign trig_edge = sel_level && !sel_prev_q; // [R14] [R15]
  assign sw_start = wr_ctrl && wr_byte[BIT_START] && wr_byte[BIT_ENABLE];
  assign free_restart = conv_done && auto_q && ts_q == TS_FREE_RUN; // [R2]
  assign conv_done = busy_q && tick && left_cnt_q == 5'h01;
  // auto trigger only counts with the feature switched on; a software
  // start may carry the enable bit in the same write, so it needs no enable_q
  assign start_req = !busy_q &&
    (sw_start || (enable_q && auto_q && trig_edge)) || // [R1] [R5] [R13]
    (enable_q && free_restart && !wr_ctrl);

  always_ff @(posedge CLK) begin
    if (SYS_RST) sel_prev_q <= 1'b0;
    else sel_prev_q <= sel_level;
  end

  // ---------------------------------------------------------------
  // control fields written by software
  // ---------------------------------------------------------------
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      enable_q <= RST_BYTE[BIT_ENABLE];
      auto_q <= RST_BYTE[BIT_AUTO];
      irq_en_q <= RST_BYTE[BIT_IRQ_EN];
      ps_q <= RST_BYTE[2:0];
    end else if (wr_ctrl) begin
      enable_q <= wr_byte[BIT_ENABLE];
      auto_q <= wr_byte[BIT_AUTO];
      irq_en_q <= wr_byte[BIT_IRQ_EN];
      ps_q <= wr_byte[BIT_PS_LO +: 3];
    end
  end

  // comparator, trigger, mux and disable registers
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      comparator_mux_enable_q <= 1'b0;
      ts_q <= RST_BYTE[2:0];
      ref_q <= 2'h0;
      left_q <= 1'b0;
      chan_q <= 4'h0;
      didr_q <= RST_BYTE;
    end else if (wr_fire && wr_lane) begin
      if (wr_idx == IDX_TRIG_COMP) begin
        comparator_mux_enable_q <= wr_byte[BIT_COMPARATOR_MUX_ENABLE];
        ts_q <= wr_byte[BIT_TS_LO +: 3];
      end
      if (wr_idx == IDX_MUX_SELECT) begin
        ref_q <= wr_byte[BIT_REF_LO +: 2];
        left_q <= wr_byte[BIT_LEFT];
        chan_q <= wr_byte[BIT_CH_LO +: 4];
      end
      if (wr_idx == IDX_DIG_DISABLE) didr_q <= wr_byte;
    end
  end

  // ---------------------------------------------------------------
  // conversion sequencer
  // ---------------------------------------------------------------
  // first_q marks a pending initialisation conversion after enabling
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      busy_q <= 1'b0;
      first_q <= 1'b0;
      left_cnt_q <= 5'h00;
    end else if (!enable_q && !(wr_ctrl && wr_byte[BIT_ENABLE])) begin
      busy_q <= 1'b0; // [R18]
      first_q <= 1'b0;
      left_cnt_q <= 5'h00;
    end else begin
      if (!enable_q) first_q <= 1'b1; // [R3]
      if (start_req) begin
        busy_q <= 1'b1; // [R4]
        first_q <= 1'b0;
        left_cnt_q <= (first_q || !enable_q) ? CONV_FIRST_CYC :
          CONV_NORMAL_CYC; // [R3]
      end else if (conv_done) begin
        busy_q <= 1'b0; // [R4]
      end else if (busy_q && tick) begin
        left_cnt_q <= left_cnt_q - 5'h01;
      end
      // abort by a disabling write in the same cycle
      if (wr_ctrl && !wr_byte[BIT_ENABLE]) busy_q <= 1'b0; // [R18]
    end
  end

  // ---------------------------------------------------------------
  // completion flag: hardware set wins over any clear
  // ---------------------------------------------------------------
  assign flag_clr = VECTOR_TAKEN || (wr_ctrl && wr_byte[BIT_FLAG]); // [R8]
  always_ff @(posedge CLK) begin
    if (SYS_RST) flag_q <= RST_BYTE[BIT_FLAG];
    else if (conv_done) flag_q <= 1'b1; // [R6]
    else if (flag_clr) flag_q <= 1'b0; // [R8]
  end

  // ---------------------------------------------------------------
  // result capture and read lock
  // ---------------------------------------------------------------
  always_ff @(posedge CLK) begin
    if (SYS_RST) result_q <= 10'h000;
    else if (conv_done && !lock_q) result_q <= core_res_s; // [R20] [R6]
  end

  // low byte read locks, high byte read releases
  always_ff @(posedge CLK) begin
    if (SYS_RST) lock_q <= 1'b0;
    else if (rd_fire && rd_idx == IDX_RESULT_LOW) lock_q <= 1'b1; // [R10]
    else if (rd_fire && rd_idx == IDX_RESULT_HIGH) lock_q <= 1'b0; // [R10]
  end

  // layout follows left adjust live, no recapture needed
  assign res_low = left_q ? {result_q[1:0], 6'h00} : result_q[7:0]; // [R11]
  assign res_high = left_q ? result_q[9:2] : {6'h00, result_q[9:8]}; // [R11]

  // ---------------------------------------------------------------
  // read mux
  // ---------------------------------------------------------------
  always_comb begin
    rd_byte = 8'h00;
    rd_hit = 1'b1;
    unique case (rd_idx)
      IDX_RESULT_LOW: rd_byte = res_low;
      IDX_RESULT_HIGH: rd_byte = res_high;
      IDX_CTRL_STATUS: rd_byte = {enable_q, busy_q, auto_q, flag_q,
        irq_en_q, ps_q}; // [R4]
      IDX_TRIG_COMP: rd_byte = {1'b0, comparator_mux_enable_q, 3'h0, ts_q};
      IDX_MUX_SELECT: rd_byte = {ref_q, left_q, 1'b0, chan_q};
      IDX_DIG_DISABLE: rd_byte = didr_q;
      default: rd_hit = 1'b0;
    endcase
  end

  // ---------------------------------------------------------------
  // write channel: address and data taken together once both wait
  // ---------------------------------------------------------------
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      S_AXI_AWREADY <= 1'b0;
      S_AXI_WREADY <= 1'b0;
      S_AXI_BVALID <= 1'b0;
      S_AXI_BRESP <= RESP_OKAY;
    end else begin
      S_AXI_AWREADY <= S_AXI_AWVALID && S_AXI_WVALID && !S_AXI_AWREADY &&
        !S_AXI_BVALID;
      S_AXI_WREADY <= S_AXI_AWVALID && S_AXI_WVALID && !S_AXI_AWREADY &&
        !S_AXI_BVALID;
      if (wr_fire) begin
        S_AXI_BVALID <= 1'b1;
        S_AXI_BRESP <= (wr_idx inside {IDX_RESULT_LOW, IDX_RESULT_HIGH,
          IDX_CTRL_STATUS, IDX_TRIG_COMP, IDX_MUX_SELECT,
          IDX_DIG_DISABLE}) ? RESP_OKAY : RESP_SLVERR;
      end else if (S_AXI_BREADY) begin
        S_AXI_BVALID <= 1'b0;
      end
    end
  end

  // read channel: data registered one cycle after the address is taken
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      S_AXI_ARREADY <= 1'b0;
      S_AXI_RVALID <= 1'b0;
      S_AXI_RDATA <= 32'h0000_0000;
      S_AXI_RRESP <= RESP_OKAY;
    end else begin
      S_AXI_ARREADY <= S_AXI_ARVALID && !S_AXI_ARREADY && !S_AXI_RVALID;
      if (rd_fire) begin
        S_AXI_RVALID <= 1'b1;
        S_AXI_RDATA <= {24'h00_0000, rd_byte};
        S_AXI_RRESP <= rd_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (S_AXI_RREADY) begin
        S_AXI_RVALID <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------
  // outputs to core, comparator, port logic and interrupt controller
  // ---------------------------------------------------------------
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      IRQ <= 1'b0;
      CORE_ACTIVE <= 1'b0;
      CORE_SAMPLE <= 1'b0;
      CORE_CHANNEL <= 4'h0;
      CORE_REFERENCE <= 2'h0;
      COMP_NEG_FROM_MUX <= 1'b0;
      DIG_IN_DISABLE <= RST_BYTE;
      PORT_IN_VALUE <= 8'h00;
    end else begin
      IRQ <= flag_q && irq_en_q && GLOBAL_INT_EN; // [R7]
      CORE_ACTIVE <= busy_q;
      CORE_SAMPLE <= start_req;
      // selection frozen while a conversion runs
      if (!busy_q || conv_done) begin
        CORE_CHANNEL <= chan_q; // [R19]
        CORE_REFERENCE <= ref_q; // [R19]
      end
      COMP_NEG_FROM_MUX <= comparator_mux_enable_q && !enable_q; // [R12]
      DIG_IN_DISABLE <= didr_q; // [R17]
      PORT_IN_VALUE <= pins_s & ~didr_q; // [R17]
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  logic [4:0] len_q;
  always_ff @(posedge CLK) begin
    if (SYS_RST || start_req) len_q <= 5'h00;
    else if (busy_q && tick) len_q <= len_q + 5'h01;
  end

  a_conv_length: assert property (@(posedge CLK) disable iff (SYS_RST) // [R3]
    conv_done |-> (len_q == 5'h0c || len_q == 5'h18))
    else $error("conversion length is not 13 or 25 clocks");
  a_flag_on_done: assert property (@(posedge CLK) disable iff (SYS_RST) // [R6]
    conv_done |=> flag_q && busy_q == $past(start_req))
    else $error("flag not set at completion");
  a_irq_needs_all: assert property (@(posedge CLK) disable iff (SYS_RST) // [R7]
    IRQ |-> $past(flag_q) && $past(irq_en_q) && $past(GLOBAL_INT_EN))
    else $error("interrupt without flag and enables");
  a_flag_clear: assert property (@(posedge CLK) disable iff (SYS_RST) // [R8]
    flag_q && VECTOR_TAKEN && !conv_done |=> !flag_q)
    else $error("flag not cleared by vector");
  a_lock_holds: assert property (@(posedge CLK) disable iff (SYS_RST) // [R10]
    lock_q && !(rd_fire && rd_idx == IDX_RESULT_HIGH) |=> $stable(result_q))
    else $error("result changed while locked");
  a_abort_off: assert property (@(posedge CLK) disable iff (SYS_RST) // [R18]
    wr_ctrl && !wr_byte[BIT_ENABLE] |=> !busy_q ##1 !CORE_ACTIVE)
    else $error("conversion not aborted by disable");
  a_no_idle_trig: assert property (@(posedge CLK) disable iff (SYS_RST) // [R13]
    !auto_q && !busy_q && !wr_ctrl |=> !busy_q)
    else $error("start without request while auto trigger off");
  a_port_masked: assert property (@(posedge CLK) disable iff (SYS_RST) // [R17]
    (pins_s & didr_q) != 8'h00 |=> (PORT_IN_VALUE & $past(didr_q)) == 8'h00)
    else $error("disabled pin reads nonzero");
  a_left_layout: assert property (@(posedge CLK) disable iff (SYS_RST) // [R11]
    left_q |-> res_high == result_q[9:2] && res_low[5:0] == 6'h00)
    else $error("left adjusted layout wrong");
endmodule : acc_conv_ctrl

// >>> hw/acc_pkg.sv
// shared constants for the converter control block
package acc_pkg;

  // ---------------------------------------------------------------
  // register indices (byte address is four times the index)
  // ---------------------------------------------------------------
  localparam logic [7:0] IDX_RESULT_LOW = 8'h78;
  localparam logic [7:0] IDX_RESULT_HIGH = 8'h79;
  localparam logic [7:0] IDX_CTRL_STATUS = 8'h7a;
  localparam logic [7:0] IDX_TRIG_COMP = 8'h7b;
  localparam logic [7:0] IDX_MUX_SELECT = 8'h7c;
  localparam logic [7:0] IDX_DIG_DISABLE = 8'h7e;

  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int BIT_ENABLE = 7;
  localparam int BIT_START = 6;
  localparam int BIT_AUTO = 5;
  localparam int BIT_FLAG = 4;
  localparam int BIT_IRQ_EN = 3;
  localparam int BIT_PS_LO = 0;
  localparam int BIT_COMPARATOR_MUX_ENABLE = 6;
  localparam int BIT_TS_LO = 0;
  localparam int BIT_REF_LO = 6;
  localparam int BIT_LEFT = 5;
  localparam int BIT_CH_LO = 0;

  // ---------------------------------------------------------------
  // reset values and codes
  // ---------------------------------------------------------------
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [2:0] TS_FREE_RUN = 3'h0;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ---------------------------------------------------------------
  // conversion lengths in converter clock cycles
  // ---------------------------------------------------------------
  localparam logic [4:0] CONV_FIRST_CYC = 5'h19;
  localparam logic [4:0] CONV_NORMAL_CYC = 5'h0d;

endpackage : acc_pkg

// >>> hw/acc_prescale.sv
// system clock divider giving one tick per converter clock cycle
`timescale 1ns/1ns
module acc_prescale (
  input wire logic CLK,
  input wire logic SYS_RST,
  input wire logic RUN,
  input wire logic [2:0] SEL,
  output logic TICK
);
  logic [6:0] cnt_q;
  logic [6:0] last;

  // codes 0 and 1 both divide by two; the rest double per step
  always_comb begin
    last = 7'h01;
    if (SEL > 3'h1) last = 7'((8'h01 << SEL) - 8'h01);
  end

  // counter idles at zero while the converter is off to save power
  always_ff @(posedge CLK) begin
    if (SYS_RST || !RUN) begin
      cnt_q <= 7'h00;
      TICK <= 1'b0;
    end else begin
      TICK <= (cnt_q >= last);
      cnt_q <= (cnt_q >= last) ? 7'h00 : cnt_q + 7'h01;
    end
  end
endmodule : acc_prescale

// >>> hw/acc_sync2.sv
// two-flop synchroniser for a bus of independent levels
`timescale 1ns/1ns
module acc_sync2 #(
  parameter int WIDTH = 8
) (
  input wire logic CLK,
  input wire logic SYS_RST,
  input wire logic [WIDTH-1:0] D,
  output logic [WIDTH-1:0] Q
);
  logic [WIDTH-1:0] meta_q;

  initial begin
    if (WIDTH < 1) $error("acc_sync2: WIDTH must be at least 1");
  end

  // first stage feeds only the second stage
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      meta_q <= '0;
      Q <= '0;
    end else begin
      meta_q <= D;
      Q <= meta_q;
    end
  end
endmodule : acc_sync2

// >>> sim/acc_core_model.sv
// behavioural analog core returning one value per conversion
`timescale 1ns/1ns
module acc_core_model (
  input wire logic CLK,
  input wire logic SYS_RST,
  input wire logic CORE_SAMPLE,
  input wire logic CORE_ACTIVE,
  input wire logic [9:0] VALUE,
  output logic [9:0] CORE_RESULT
);
  logic [9:0] held_q;
  // take the level at the start pulse and hold it for the whole conversion
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      held_q <= 10'h155;
    end else if (CORE_SAMPLE) begin
      held_q <= VALUE;
    end
  end
  // idle core shows the inverse, so a late capture cannot pass by chance
  assign CORE_RESULT = CORE_ACTIVE ? held_q : ~held_q;
endmodule : acc_core_model

// >>> sim/tb_acc_conv_ctrl.sv
// self-checking bench for the converter control block
`timescale 1ns/1ns
module tb_acc_conv_ctrl;
  import acc_pkg::*;
  // ---------------------------------------------------------------
  // signals
  // ---------------------------------------------------------------
  logic CLK, SYS_RST, S_AXI_AWVALID, S_AXI_AWREADY, S_AXI_WVALID;
  logic S_AXI_WREADY, S_AXI_BVALID, S_AXI_BREADY, S_AXI_ARVALID;
  logic S_AXI_ARREADY, S_AXI_RVALID, S_AXI_RREADY, GLOBAL_INT_EN;
  logic VECTOR_TAKEN, IRQ, CORE_ACTIVE, CORE_SAMPLE, COMP_NEG_FROM_MUX;
  logic [9:0] S_AXI_AWADDR, S_AXI_ARADDR, VALUE, CORE_RESULT;
  logic [31:0] S_AXI_WDATA, S_AXI_RDATA, rd_q;
  logic [3:0] S_AXI_WSTRB, CORE_CHANNEL;
  logic [1:0] S_AXI_BRESP, S_AXI_RRESP, CORE_REFERENCE, rsp;
  logic [7:0] TRIG_FLAGS, PIN_LEVELS, DIG_IN_DISABLE, PORT_IN_VALUE;
  int mismatches, comparisons, cyc, act_n, smp_n;

  acc_conv_ctrl #(.ADDR_W(10)) DUT (.*);
  acc_core_model core (.*);

  initial begin
    CLK = 1'b0;
    forever #50 CLK = ~CLK;
  end
  // busy length and start pulses are counted beside the tasks
  always @(posedge CLK) begin
    cyc <= cyc + 1;
    if (CORE_ACTIVE === 1'b1) act_n <= act_n + 1;
    if (CORE_SAMPLE === 1'b1) smp_n <= smp_n + 1;
    if (cyc == 20000) begin
      mismatches++;
      report_and_stop();
    end
  end
  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : report_and_stop
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      mismatches++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // write and address released each at its own ready; bready stays high
  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    S_AXI_AWADDR <= {idx, 2'b00};
    S_AXI_WDATA <= {24'h000000, d};
    S_AXI_AWVALID <= 1'b1;
    S_AXI_WVALID <= 1'b1;
    do begin
      @(posedge CLK);
      if (S_AXI_AWREADY === 1'b1) S_AXI_AWVALID <= 1'b0;
      if (S_AXI_WREADY === 1'b1) S_AXI_WVALID <= 1'b0;
    end while (S_AXI_BVALID !== 1'b1);
    rsp = S_AXI_BRESP;
  endtask : wr
  task automatic rd(input logic [7:0] idx);
    S_AXI_ARADDR <= {idx, 2'b00};
    S_AXI_ARVALID <= 1'b1;
    do begin
      @(posedge CLK);
      if (S_AXI_ARREADY === 1'b1) S_AXI_ARVALID <= 1'b0;
    end while (S_AXI_RVALID !== 1'b1);
    rd_q = S_AXI_RDATA;
    rsp = S_AXI_RRESP;
  endtask : rd
  task automatic rchk(input logic [7:0] idx, input logic [7:0] e);
    rd(idx);
    chk(rd_q, {24'h000000, e});
  endtask : rchk
  task automatic idle;
    while (CORE_ACTIVE === 1'b1) @(posedge CLK);
    repeat (2) @(posedge CLK);
  endtask : idle
  // start a conversion and judge its length against ticks times divider
  task automatic run(input logic [7:0] c, input int t, input int d);
    act_n <= 0;
    wr(IDX_CTRL_STATUS, c);
    rd(IDX_CTRL_STATUS);
    chk(rd_q[BIT_START], 1'b1);
    idle();
    chk((act_n > (t - 1) * d - 4 && act_n <= t * d + 2) ? t * d : act_n,
        t * d);
  endtask : run
  task automatic samples(input int e);
    repeat (8) @(posedge CLK);
    chk(smp_n, e);
    idle();
  endtask : samples
  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic t_regs;
    rchk(IDX_RESULT_LOW, RST_BYTE);
    rchk(IDX_RESULT_HIGH, RST_BYTE);
    rchk(IDX_TRIG_COMP, RST_BYTE);
    rchk(IDX_DIG_DISABLE, RST_BYTE);
    wr(IDX_RESULT_LOW, 8'hff);
    rchk(IDX_RESULT_LOW, RST_BYTE);
    rchk(IDX_RESULT_HIGH, RST_BYTE);
    rd(8'h7d);
    chk(rsp, RESP_SLVERR);
    wr(8'h70, 8'h01);
    chk(rsp, RESP_SLVERR);
    $display("test regs done");
  endtask : t_regs
  task automatic t_single;
    VALUE <= 10'h2c5;
    run(8'hc0, 25, 2);
    rchk(IDX_CTRL_STATUS, 8'h90);
    rchk(IDX_RESULT_LOW, 8'hc5);
    rchk(IDX_RESULT_HIGH, 8'h02);
    run(8'hc0, 13, 2);
    smp_n <= 0;
    wr(IDX_CTRL_STATUS, 8'h80);
    samples(0);
    for (int p = 0; p < 8; p++) begin
      run(8'hc0 | 8'(p), 13, (p < 2) ? 2 : (1 << p));
    end
    $display("test single done");
  endtask : t_single
  task automatic t_irq;
    wr(IDX_CTRL_STATUS, 8'h88);
    repeat (2) @(posedge CLK);
    chk(IRQ, 1'b1);
    GLOBAL_INT_EN <= 1'b0;
    repeat (3) @(posedge CLK);
    chk(IRQ, 1'b0);
    GLOBAL_INT_EN <= 1'b1;
    VECTOR_TAKEN <= 1'b1;
    @(posedge CLK);
    VECTOR_TAKEN <= 1'b0;
    repeat (3) @(posedge CLK);
    chk(IRQ, 1'b0);
    run(8'hc8, 13, 2);
    chk(IRQ, 1'b1);
    wr(IDX_CTRL_STATUS, 8'h80);
    repeat (2) @(posedge CLK);
    chk(IRQ, 1'b0);
    wr(IDX_CTRL_STATUS, 8'h90);
    rchk(IDX_CTRL_STATUS, 8'h80);
    $display("test irq done");
  endtask : t_irq
  task automatic t_lock;
    rchk(IDX_RESULT_LOW, 8'hc5);
    VALUE <= 10'h13a;
    run(8'hc0, 13, 2);
    rchk(IDX_RESULT_HIGH, 8'h02);
    rchk(IDX_RESULT_LOW, 8'hc5);
    rchk(IDX_RESULT_HIGH, 8'h02);
    run(8'hc0, 13, 2);
    rchk(IDX_RESULT_LOW, 8'h3a);
    rchk(IDX_RESULT_HIGH, 8'h01);
    wr(IDX_MUX_SELECT, 8'h20);
    rchk(IDX_RESULT_LOW, 8'h80);
    rchk(IDX_RESULT_HIGH, 8'h4e);
    wr(IDX_MUX_SELECT, 8'h00);
    $display("test lock done");
  endtask : t_lock
  task automatic t_abort;
    wr(IDX_CTRL_STATUS, 8'hd7);
    wr(IDX_MUX_SELECT, 8'h45);
    chk(CORE_CHANNEL, 4'h0);
    idle();
    chk({CORE_REFERENCE, CORE_CHANNEL}, 6'h15);
    wr(IDX_CTRL_STATUS, 8'hd7);
    repeat (20) @(posedge CLK);
    wr(IDX_CTRL_STATUS, 8'h00);
    repeat (3) @(posedge CLK);
    chk(CORE_ACTIVE, 1'b0);
    rchk(IDX_CTRL_STATUS, 8'h00);
    $display("test abort done");
  endtask : t_abort
  task automatic t_trig;
    wr(IDX_CTRL_STATUS, 8'h80);
    wr(IDX_TRIG_COMP, 8'h01);
    smp_n <= 0;
    TRIG_FLAGS <= 8'h02;
    samples(0);
    wr(IDX_CTRL_STATUS, 8'ha0);
    for (int k = 1; k < 8; k++) begin
      TRIG_FLAGS <= 8'h00;
      wr(IDX_TRIG_COMP, 8'(k));
      smp_n <= 0;
      TRIG_FLAGS <= 8'(1 << k);
      samples(1);
    end
    TRIG_FLAGS <= 8'h08;
    wr(IDX_TRIG_COMP, 8'h02);
    smp_n <= 0;
    wr(IDX_TRIG_COMP, 8'h03);
    samples(1);
    smp_n <= 0;
    wr(IDX_TRIG_COMP, 8'h00);
    samples(0);
    wr(IDX_CTRL_STATUS, 8'he0);
    repeat (120) @(posedge CLK);
    chk(32'(smp_n > 3), 32'h1);
    wr(IDX_CTRL_STATUS, 8'h00);
    idle();
    smp_n <= 0;
    samples(0);
    $display("test trig done");
  endtask : t_trig
  task automatic t_pins;
    wr(IDX_TRIG_COMP, 8'h40);
    repeat (2) @(posedge CLK);
    chk(COMP_NEG_FROM_MUX, 1'b1);
    wr(IDX_CTRL_STATUS, 8'h80);
    repeat (2) @(posedge CLK);
    chk(COMP_NEG_FROM_MUX, 1'b0);
    PIN_LEVELS <= 8'hff;
    wr(IDX_DIG_DISABLE, 8'ha5);
    repeat (4) @(posedge CLK);
    chk({DIG_IN_DISABLE, PORT_IN_VALUE}, 16'ha55a);
    rchk(IDX_DIG_DISABLE, 8'ha5);
    $display("test pins done");
  endtask : t_pins
  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    {SYS_RST, S_AXI_BREADY, S_AXI_RREADY, GLOBAL_INT_EN} = 4'hf;
    {S_AXI_AWVALID, S_AXI_WVALID, S_AXI_ARVALID, VECTOR_TAKEN} = 4'h0;
    {S_AXI_AWADDR, S_AXI_ARADDR, VALUE} = 30'h0;
    {S_AXI_WDATA, S_AXI_WSTRB} = 36'h00000000f;
    {TRIG_FLAGS, PIN_LEVELS} = 16'h0000;
    repeat (4) @(posedge CLK);
    SYS_RST <= 1'b0;
    @(posedge CLK);
    t_regs();
    t_single();
    t_irq();
    t_lock();
    t_abort();
    t_trig();
    t_pins();
    report_and_stop();
  end
endmodule : tb_acc_conv_ctrl
